/* sim/host_line_model.sv */
// Host pin driver standing in for the controller
`timescale 1ns/10ps
module host_line_model (
  // Clock
  input wire logic clock,
  // Line to the device
  output logic ctrl_line
);
  initial ctrl_line = 1'b0;
  // Holds a level n cycles; callers keep pulses short of both windows
  task automatic drive(input logic lvl, input int unsigned n);
    ctrl_line <= lvl;
    repeat (n) @(posedge clock);
  endtask : drive
endmodule : host_line_model

/* sim/rail_prog_monitor.sv */
// Port checker for the rail programmer
`timescale 1ns/10ps
module rail_prog_monitor
  import rail_prog_pkg::*;
#(
  parameter int unsigned STORE_CYCLES = 40,
  parameter int unsigned OFF_CYCLES = 60
) (
  // Inputs
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic ctrl_line,
  input wire rail_sense_t sense,
  // Outputs
  input wire logic [CODE_W-1:0] dac_code,
  input wire logic enabled,
  input wire logic code_stored,
  input wire power_ctl_t power_ctl
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Enable and programming
  a_enable_default: assert property (
    $rose(enabled) |-> dac_code == '0 && $past(ctrl_line, 2)) else $error("bad enable");
  a_store_wait: assert property (
    enabled && $changed(dac_code) && dac_code != '0 |->
    $past(ctrl_line, 4) && $past(ctrl_line, STORE_CYCLES - 10)) else $error("early store");
  a_off_window: assert property (
    $fell(enabled) |-> !$past(ctrl_line, 3) && !$past(ctrl_line, OFF_CYCLES - 10))
    else $error("early shutdown");
  a_shut_clear: assert property (
    (!enabled)[*3] |-> power_ctl == '0 && dac_code == '0 && !code_stored)
    else $error("not cleared");
  // Phases; limits are registered, so settling cycles are allowed
  a_phase_one: assert property (
    $rose(enabled) ##0 (sense == '0)[*3] |-> !power_ctl.ldo_connect &&
    power_ctl.neg_sw_limit == LIM_REDUCED) else $error("no phase one");
  a_phase_two: assert property (
    (enabled && sense.neg_below_0v4 && !sense.pos_above_3v)[*8] |->
    power_ctl.ldo_limit == LIM_STEP2 && power_ctl.pos_sw_limit == LIM_STEP2)
    else $error("no phase two");
  a_full_only: assert property (
    power_ctl.pos_sw_limit == LIM_FULL |-> $past(sense.pos_above_3v && sense.neg_below_1v))
    else $error("full too soon");
  a_off_time: assert property (
    (enabled && $stable(sense.ccm))[*4] |-> power_ctl.fixed_off_time == sense.ccm)
    else $error("bad timing mode");
endmodule : rail_prog_monitor

bind pulse_count_rail_programmer rail_prog_monitor #(
  .STORE_CYCLES(STORE_CYCLES), .OFF_CYCLES(OFF_CYCLES)
) u_monitor (.clock, .resetn, .clk_en, .ctrl_line, .sense, .dac_code, .enabled,
  .code_stored, .power_ctl);

/* sim/tb_top.sv */
// Self-checking bench for the rail programmer
`timescale 1ns/10ps
module tb_top;
  import rail_prog_pkg::*;
  localparam int unsigned ST = 40;
  localparam int unsigned OF = 60;
  logic clock, resetn, clk_en, ctrl_line, enabled, code_stored;
  rail_sense_t sense;
  logic [4:0] dac_code;
  power_ctl_t power_ctl;
  int failures = 0, n_checks = 0, seed, cyc = 0;
  int counts[5] = '{1, 4, 31, 35, 0};
  // Clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  pulse_count_rail_programmer #(.STORE_CYCLES(ST), .OFF_CYCLES(OF)) u_dut (.clock, .resetn,
    .clk_en, .ctrl_line, .sense, .dac_code, .enabled, .code_stored, .power_ctl);
  host_line_model u_host (.clock, .ctrl_line);
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] seen);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Counts past 31 saturate
  function automatic logic [4:0] exp_code(input int n);
    return (n > 31) ? 5'h1f : n[4:0];
  endfunction : exp_code
  function automatic power_ctl_t exp_pwr(input limit_t sw, input logic ccm);
    power_ctl_t p;
    p = '{sw, sw, sw, 1'b1, ccm, 1'b1};
    if (sw == LIM_REDUCED) begin
      p.ldo_limit = LIM_OFF;
      p.ldo_connect = 1'b0;
    end
    return p;
  endfunction : exp_pwr
  task automatic set_sense(input logic [3:0] v);
    sense <= v;
    repeat (10) @(posedge clock);
  endtask : set_sense
  task automatic test_done;
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      test_done();
    end
  end
  // Main sequence: enable, burst, store, phases, shutdown
  initial begin
    seed = 94;
    resetn = 1'b0;
    clk_en = 1'b1;
    sense = '0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    check("reset", 9'h000, {2'h0, enabled, code_stored, dac_code});
    counts[4] = 2 + $unsigned($random(seed)) % 29;
    for (int i = 0; i < 5; i++) begin
      u_host.drive(1'b1, 8);
      check("enable", 9'h040, {2'h0, enabled, code_stored, dac_code});
      check("phase one", exp_pwr(LIM_REDUCED, 1'b0), power_ctl);
      for (int k = 0; k < counts[i]; k++) begin
        u_host.drive(1'b0, 8 + $unsigned($random(seed)) % 40);
        u_host.drive(1'b1, 8 + $unsigned($random(seed)) % 20);
      end
      u_host.drive(1'b1, ST + 10);
      check("code", {4'h3, exp_code(counts[i])}, {2'h0, enabled, code_stored, dac_code});
      if (i == 0) begin
        set_sense(4'h8);
        check("phase two", exp_pwr(LIM_STEP2, 1'b0), power_ctl);
        set_sense(4'he);
        check("full", exp_pwr(LIM_FULL, 1'b0), power_ctl);
        set_sense(4'hc);
        check("short", exp_pwr(LIM_STEP2, 1'b0), power_ctl);
        set_sense(4'h9);
        check("ccm", exp_pwr(LIM_STEP2, 1'b1), power_ctl);
        set_sense(4'h0);
        // Frozen clock enable must hold state through a long low
        clk_en <= 1'b0;
        u_host.drive(1'b0, OF + 12);
        check("freeze", {4'h3, exp_code(counts[0])}, {2'h0, enabled, code_stored, dac_code});
        clk_en <= 1'b1;
      end
      u_host.drive(1'b0, OF + 12);
      check("shutdown", 9'h000, {2'h0, enabled, code_stored, dac_code});
      check("power off", 9'h000, power_ctl);
    end
    test_done();
  end
endmodule : tb_top

/* verilog/pulse_count_rail_programmer.sv */
// Enable, pulse-count programming and start-up sequencing of the rails
`timescale 1ns/10ps
module pulse_count_rail_programmer
  import rail_prog_pkg::*;
#(
  parameter int unsigned STORE_CYCLES = STORE_CYC,
  parameter int unsigned OFF_CYCLES = OFF_CYC
) (
  // Clock, reset, clock enable
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // Control line from the host
  input wire logic ctrl_line,
  // Rail comparators
  input wire rail_sense_t sense,
  // Rail code and status
  output logic [CODE_W-1:0] dac_code,
  output logic enabled,
  output logic code_stored,
  // Power stage controls
  output power_ctl_t power_ctl
);

  typedef enum logic [1:0] {SEQ_OFF, SEQ_PHASE1, SEQ_PHASE2, SEQ_FULL} seq_t;

  logic line_meta_ff;
  logic line_sync_ff;
  logic line_prev_ff;
  logic enabled_ff;
  logic [CODE_W-1:0] edge_cnt_ff;
  logic [CODE_W-1:0] code_ff;
  logic stored_ff;
  logic store_pending_ff;
  seq_t seq_ff;
  seq_t nxt_seq;
  power_ctl_t ctl_ff;
  power_ctl_t nxt_ctl;
  logic rise;
  logic low_expired;
  logic high_expired;

  // Two-stage synchroniser for the asynchronous pin
  always_ff @(posedge clock) begin
    if (!resetn) begin
      line_meta_ff <= 1'b0;
      line_sync_ff <= 1'b0;
      line_prev_ff <= 1'b0;
    end else if (clk_en) begin
      line_meta_ff <= ctrl_line;
      line_sync_ff <= line_meta_ff;
      line_prev_ff <= line_sync_ff;
    end
  end

  assign rise = line_sync_ff & ~line_prev_ff;

  // Low-time timer separates pulse gaps from shutdown
  pulse_timer #(
    .LIMIT(OFF_CYCLES)
  ) u_low_timer (
    .clock(clock),
    .resetn(resetn),
    .clk_en(clk_en),
    .run(~line_sync_ff),
    .expired(low_expired)
  );

  // High-time timer closes the programming burst
  pulse_timer #(
    .LIMIT(STORE_CYCLES)
  ) u_high_timer (
    .clock(clock),
    .resetn(resetn),
    .clk_en(clk_en),
    .run(line_sync_ff),
    .expired(high_expired)
  );

  // Enable follows a rising edge from off, drops after a long low
  always_ff @(posedge clock) begin
    if (!resetn) begin
      enabled_ff <= 1'b0;
    end else if (clk_en) begin
      if (!enabled_ff && rise) begin
        enabled_ff <= 1'b1;
      end else if (enabled_ff && low_expired) begin
        enabled_ff <= 1'b0;
      end
    end
  end

  // Edge counter; the enabling edge itself is not counted
  always_ff @(posedge clock) begin
    if (!resetn) begin
      edge_cnt_ff <= CODE_DEFAULT;
    end else if (clk_en) begin
      if (!enabled_ff) begin
        edge_cnt_ff <= CODE_DEFAULT;
      end else if (rise && edge_cnt_ff != CODE_MAX) begin
        edge_cnt_ff <= edge_cnt_ff + 5'h01;
      end
    end
  end

  // Pending marks a burst not yet stored; set wins over the store
  always_ff @(posedge clock) begin
    if (!resetn) begin
      store_pending_ff <= 1'b0;
    end else if (clk_en) begin
      if (!enabled_ff) begin
        store_pending_ff <= 1'b0;
      end else if (rise) begin
        store_pending_ff <= 1'b1;
      end else if (high_expired) begin
        store_pending_ff <= 1'b0;
      end
    end
  end

  // Code loads after the line stays high past the storage window.
  // Holding the old code until then avoids the rail wandering mid-burst.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      code_ff <= CODE_DEFAULT;
      stored_ff <= 1'b0;
    end else if (clk_en) begin
      if (!enabled_ff) begin
        code_ff <= CODE_DEFAULT;
        stored_ff <= 1'b0;
      end else if (store_pending_ff && high_expired) begin
        code_ff <= edge_cnt_ff;
        stored_ff <= 1'b1;
      end
    end
  end

  // Start-up phase sequencing from the rail comparators
  always_comb begin
    nxt_seq = seq_ff;
    unique case (seq_ff)
      SEQ_OFF: begin
        if (enabled_ff) begin
          nxt_seq = SEQ_PHASE1;
        end
      end
      SEQ_PHASE1: begin
        if (sense.neg_below_0v4) begin
          nxt_seq = SEQ_PHASE2;
        end
      end
      SEQ_PHASE2: begin
        // A rail short collapses the negative rail and drops back to phase one
        if (!sense.neg_below_0v4) begin
          nxt_seq = SEQ_PHASE1;
        end else if (sense.pos_above_3v && sense.neg_below_1v) begin
          nxt_seq = SEQ_FULL;
        end
      end
      SEQ_FULL: begin
        if (!(sense.pos_above_3v && sense.neg_below_1v)) begin
          nxt_seq = SEQ_PHASE1;
        end
      end
    endcase
    if (!enabled_ff) begin
      nxt_seq = SEQ_OFF;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      seq_ff <= SEQ_OFF;
    end else if (clk_en) begin
      seq_ff <= nxt_seq;
    end
  end

  // Power stage settings per phase
  always_comb begin
    nxt_ctl = '0;
    nxt_ctl.pos_sw_limit = LIM_OFF;
    nxt_ctl.neg_sw_limit = LIM_OFF;
    nxt_ctl.ldo_limit = LIM_OFF;
    nxt_ctl.fixed_off_time = sense.ccm;
    unique case (nxt_seq)
      SEQ_OFF: begin
        nxt_ctl.ldo_connect = 1'b0;
        nxt_ctl.fixed_off_time = 1'b0;
      end
      SEQ_PHASE1: begin
        nxt_ctl.conv_enable = 1'b1;
        nxt_ctl.pos_sw_limit = LIM_REDUCED;
        nxt_ctl.neg_sw_limit = LIM_REDUCED;
      end
      SEQ_PHASE2: begin
        nxt_ctl.conv_enable = 1'b1;
        nxt_ctl.ldo_connect = 1'b1;
        nxt_ctl.ldo_limit = LIM_STEP2;
        nxt_ctl.pos_sw_limit = LIM_STEP2;
        nxt_ctl.neg_sw_limit = LIM_STEP2;
      end
      SEQ_FULL: begin
        nxt_ctl.conv_enable = 1'b1;
        nxt_ctl.ldo_connect = 1'b1;
        nxt_ctl.ldo_limit = LIM_FULL;
        nxt_ctl.pos_sw_limit = LIM_FULL;
        nxt_ctl.neg_sw_limit = LIM_FULL;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctl_ff <= '0;
    end else if (clk_en) begin
      ctl_ff <= nxt_ctl;
    end
  end

  // Outputs from flip-flops
  assign dac_code = code_ff;
  assign enabled = enabled_ff;
  assign code_stored = stored_ff;
  assign power_ctl = ctl_ff;

endmodule : pulse_count_rail_programmer

/* verilog/pulse_timer.sv */
// Saturating run-length timer for one line level
`timescale 1ns/10ps
module pulse_timer
  import rail_prog_pkg::*;
#(
  parameter int unsigned LIMIT = 1000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // Control
  input wire logic run,
  // Status
  output logic expired
);

  localparam int unsigned W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIM = W'(LIMIT);

  logic [W-1:0] count_ff;

  // Restart whenever run drops; saturate at the limit
  always_ff @(posedge clock) begin
    if (!resetn) begin
      count_ff <= '0;
    end else if (clk_en) begin
      if (!run) begin
        count_ff <= '0;
      end else if (count_ff != LIM) begin
        count_ff <= count_ff + W'(1);
      end
    end
  end

  assign expired = (count_ff == LIM);

endmodule : pulse_timer

/* verilog/rail_prog_pkg.sv */
// Shared constants and carriers for the rail programmer
package rail_prog_pkg;

  // Clock rate in kHz
  localparam int unsigned CLK_KHZ = 250_000;

  // Line timing windows in microseconds
  localparam int unsigned STORE_MIN_US = 30;
  localparam int unsigned STORE_MAX_US = 80;
  localparam int unsigned OFF_MIN_US = 30;
  localparam int unsigned OFF_MAX_US = 80;
  localparam int unsigned PULSE_MIN_US = 2;
  localparam int unsigned PULSE_MAX_US = 25;

  // Cycle counts: decide at the midpoint of the store and off windows
  localparam int unsigned STORE_CYC = ((STORE_MIN_US + STORE_MAX_US) / 2) * CLK_KHZ / 1000;
  localparam int unsigned OFF_CYC = ((OFF_MIN_US + OFF_MAX_US) / 2) * CLK_KHZ / 1000;

  // Code layout
  localparam int unsigned CODE_W = 5;
  localparam logic [4:0] CODE_DEFAULT = 5'h00;
  localparam logic [4:0] CODE_MAX = 5'h1f;

  // Current limit steps for the converters and the post regulator
  typedef enum logic [1:0] {LIM_OFF, LIM_REDUCED, LIM_STEP2, LIM_FULL} limit_t;

  // Comparator inputs from the analog rails
  typedef struct packed {
    logic neg_below_0v4;  // Negative rail below -0.4 V
    logic neg_below_1v;   // Negative rail below -1 V
    logic pos_above_3v;   // Positive rail above 3 V
    logic ccm;            // Inductor current continuous
  } rail_sense_t;

  // Power stage controls
  typedef struct packed {
    limit_t pos_sw_limit;   // Boost switch limit
    limit_t neg_sw_limit;   // Inverter switch limit
    limit_t ldo_limit;      // Post regulator limit
    logic ldo_connect;      // Post regulator passes the rail
    logic fixed_off_time;   // Peak current with fixed off time
    logic conv_enable;      // Converters running
  } power_ctl_t;

endpackage : rail_prog_pkg
